// File: logic/sfdp_basic_param_table.sv
// ---------------------------------------------------------------
// sfdp_basic_param_table: read-only basic flash parameter table
// ---------------------------------------------------------------
// holds the APB slave that exposes bytes 30H..3FH and the header pointer
// assumes an APB3 master on pclk; no other clock, no interrupt
//
// Contract
// - byte 30H bits 1:0 read 01b (4KB erase); byte 31H reads 20H.
// - byte 30H bit 2 reads 1b: program granularity 64 bytes or more.
// - byte 30H bit 3 reads 0b: block-protect bits are nonvolatile.
// - byte 30H bit 4 reads 0b; bits 3 and 4 together 00b.
// - byte 30H bits 7:5 fixed 111b; whole byte reads E5H.
// - dword bits 18:17 read 00b: three-byte addressing only.
// - byte 32H reads 91H: dual reads yes, DTR and quad no.
// - quad read descriptors: zero waits, no mode bits, opcode FFH.
// - dual-output descriptor: eight dummy clocks (08H), opcode 3BH.
// - dual-I/O descriptor: mode field 100b (80H), opcode BBH.
// - table bytes are fetched with read opcode 5AH.
// - header pointer locates this table at byte address 30H.
`timescale 1ns/1ps
module sfdp_basic_param_table
    import sfdp_pkg::*;
#(
    // flash density dword, read as table bytes 34H..37H; arbitrary default
    parameter logic [31:0] DENSITY_WORD = 32'h00000000
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [ADDR_W-1:0]  paddr,
    input  wire logic [DATA_W-1:0]  pwdata,
    output logic      [DATA_W-1:0]  prdata,
    output logic                    pready,
    output logic                    pslverr
);

    // ---------------------------------------------------------------
    // constant table content
    // ---------------------------------------------------------------
    // little-endian packing: bits 7:0 are the first byte of each dword
    wire logic [7:0]  byte30 = {BYTE30_FIXED, WREN_SEL_06, BP_VOLATILE,
                                GRAN_64_PLUS, ERASE_4K_AVAIL};
    wire logic [7:0]  byte32 = {BYTE32_B7, RD_114_OK, RD_144_OK, RD_122_OK,
                                DTR_OK, ADDR_3B_ONLY, RD_112_OK};
    wire logic [31:0] tbl_dw0 = {UNUSED_BYTE, byte32, ERASE_4K_OP, byte30};
    wire logic [31:0] tbl_dw1 = DENSITY_WORD;
    wire logic [31:0] tbl_dw2 = {QUAD_OP, QUAD_MODE, QUAD_WAIT,
                                 QUAD_OP, QUAD_MODE, QUAD_WAIT};
    wire logic [31:0] tbl_dw3 = {RD122_OP, RD122_MODE, RD122_WAIT,
                                 RD112_OP, RD112_MODE, RD112_WAIT};
    wire logic [31:0] hdr_ptr = {UNUSED_BYTE, TBL_POINTER};

    // pick one byte of the table by its byte address
    function automatic logic [7:0] table_byte(input logic [7:0] a);
        logic [31:0] dw;
        dw = 32'h00000000;
        case (a[3:2])
            2'h0:    dw = tbl_dw0;
            2'h1:    dw = tbl_dw1;
            2'h2:    dw = tbl_dw2;
            default: dw = tbl_dw3;
        endcase
        table_byte = dw[8*a[1:0] +: 8];
    endfunction

    // ---------------------------------------------------------------
    // APB decode
    // ---------------------------------------------------------------
    wire logic        access_first = psel & penable & ~pready;
    wire logic        access_done  = psel & penable & pready;
    wire logic        sel_ptr      = (paddr == OFF_HDR_PTR);
    wire logic        sel_dw0      = (paddr == OFF_TBL_DW0);
    wire logic        sel_dw1      = (paddr == OFF_TBL_DW1);
    wire logic        sel_dw2      = (paddr == OFF_TBL_DW2);
    wire logic        sel_dw3      = (paddr == OFF_TBL_DW3);
    wire logic        sel_cmd      = (paddr == OFF_CMD);
    wire logic        sel_res      = (paddr == OFF_RESULT);
    wire logic        sel_table    = sel_dw0 | sel_dw1 | sel_dw2 | sel_dw3;
    wire logic        mapped       = sel_ptr | sel_table | sel_cmd | sel_res;
    // table and pointer are read-only: a write is refused, content unchanged
    wire logic        bad_write    = pwrite & ~sel_cmd;
    wire logic        acc_err      = ~mapped | bad_write;

    // ---------------------------------------------------------------
    // lookup command state
    // ---------------------------------------------------------------
    logic [7:0] cmd_opcode;
    logic [7:0] cmd_addr;
    logic [7:0] result_data;
    logic       result_valid;
    logic       result_refused;

    wire logic [7:0]  wr_op      = pwdata[7:0];
    wire logic [7:0]  wr_addr    = pwdata[15:8];
    wire logic        op_ok      = (wr_op == OP_SFDP_READ);
    wire logic        addr_ok    = (wr_addr >= TBL_FIRST) && (wr_addr <= TBL_LAST);
    wire logic        lookup_ok  = op_ok & addr_ok;
    wire logic        cmd_write  = access_done & pwrite & sel_cmd;
    wire logic [7:0]  next_result_data = lookup_ok ? table_byte(wr_addr) : UNUSED_BYTE;

    wire logic [31:0] cmd_word   = {16'h0000, cmd_addr, cmd_opcode};
    wire logic [31:0] res_word   = {22'h000000, result_refused, result_valid, result_data};

    wire logic [31:0] rd_value   = sel_ptr ? hdr_ptr :
                                   sel_dw0 ? tbl_dw0 :
                                   sel_dw1 ? tbl_dw1 :
                                   sel_dw2 ? tbl_dw2 :
                                   sel_dw3 ? tbl_dw3 :
                                   sel_cmd ? cmd_word :
                                   sel_res ? res_word : 32'h00000000;
    wire logic [31:0] next_prdata = (access_first & ~pwrite) ? rd_value : 32'h00000000;

    // ---------------------------------------------------------------
    // bus answer: one wait state, all outputs registered
    // ---------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= access_first;
            pslverr <= access_first & acc_err;
            prdata  <= next_prdata;
        end
    end

    // the write lands at the edge where the master sees pready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_opcode     <= 8'h00;
            cmd_addr       <= 8'h00;
            result_data    <= 8'h00;
            result_valid   <= 1'b0;
            result_refused <= 1'b0;
        end else if (cmd_write) begin
            cmd_opcode     <= wr_op;
            cmd_addr       <= wr_addr;
            result_data    <= next_result_data;
            result_valid   <= lookup_ok;
            result_refused <= ~lookup_ok;
        end
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    wire logic rd_done = access_done & ~pwrite;

    a_ready_one_wait: assert property (access_first |=> pready ##1 !pready)
        else $error("pready not a single pulse one cycle after access");
    a_byte30_fields: assert property (rd_done && paddr == 8'h30 |-> prdata[7:0] == 8'hE5 && prdata[15:8] == 8'h20)
        else $error("byte 30H or 31H wrong");
    a_gran_nonvol: assert property (rd_done && paddr == 8'h30 |-> prdata[2] && prdata[4:3] == 2'b00)
        else $error("granularity or status volatility bits wrong");
    a_dual_support: assert property (rd_done && paddr == 8'h30 |-> prdata[23:16] == 8'h91 && prdata[18:17] == 2'b00)
        else $error("byte 32H wrong");
    a_quad_absent: assert property (rd_done && paddr == 8'h38 |-> prdata == 32'hFF00FF00)
        else $error("quad descriptors wrong");
    a_dual_descr: assert property (rd_done && paddr == 8'h3C |-> prdata == 32'hBB803B08)
        else $error("dual descriptors wrong");
    a_hdr_pointer: assert property (rd_done && paddr == 8'h0C |-> prdata[23:0] == 24'h000030)
        else $error("header pointer not 30H");
    a_lookup_result: assert property (cmd_write && pwdata[15:0] == 16'h3D5A |=> result_data == 8'h3B && result_valid)
        else $error("lookup of 3DH did not return 3BH");
    a_wrong_opcode: assert property (cmd_write && pwdata[7:0] != 8'h5A |=> result_refused && !result_valid)
        else $error("lookup accepted without 5AH");
    a_ro_refused: assert property (access_first && pwrite && paddr == 8'h30 |=> pslverr && pready)
        else $error("write to table not refused");

    a_hdr_unused: assert property (rd_done && sel_ptr |-> prdata[31:24] == 8'hFF)
        else $error("header pointer top byte not FFH");

    a_answer_once: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");

    // ---------------------------------------------------------------
    // reference bytes, typed in apart from the packed constants
    // ---------------------------------------------------------------
    // a slip in a package field or a concatenation order above would
    // otherwise be checked against itself
    function automatic logic [7:0] ref_byte(input logic [3:0] idx);
        logic [7:0] b;
        b = 8'hFF;
        case (idx)
            4'h0:    b = 8'hE5;
            4'h1:    b = 8'h20;
            4'h2:    b = 8'h91;
            4'h3:    b = 8'hFF;
            4'h4:    b = DENSITY_WORD[7:0];
            4'h5:    b = DENSITY_WORD[15:8];
            4'h6:    b = DENSITY_WORD[23:16];
            4'h7:    b = DENSITY_WORD[31:24];
            4'h8:    b = 8'h00;
            4'h9:    b = 8'hFF;
            4'hA:    b = 8'h00;
            4'hB:    b = 8'hFF;
            4'hC:    b = 8'h08;
            4'hD:    b = 8'h3B;
            4'hE:    b = 8'h80;
            4'hF:    b = 8'hBB;
            default: b = 8'hFF;
        endcase
        ref_byte = b;
    endfunction

    wire logic [3:0]  word_idx = {paddr[3:2], 2'h0};
    wire logic [31:0] ref_word = {ref_byte(word_idx + 4'h3), ref_byte(word_idx + 4'h2),
                                  ref_byte(word_idx + 4'h1), ref_byte(word_idx)};

    // ---------------------------------------------------------------
    // field checks on table reads
    // ---------------------------------------------------------------
    a_gran_large: assert property (rd_done && sel_dw0 |-> prdata[2] == 1'b1)
        else $error("write granularity bit not set");

    a_wren_select: assert property (rd_done && sel_dw0 |-> prdata[4:3] == 2'h0)
        else $error("status write enable select bits not 00b");

    a_fixed_top: assert property (rd_done && sel_dw0 |-> prdata[7:5] == 3'h7 && prdata[7:0] == 8'hE5)
        else $error("byte 30H upper bits or whole byte wrong");

    a_addr_width: assert property (rd_done && sel_dw0 |-> prdata[18:17] == 2'h0)
        else $error("address byte count field not three-byte only");

    a_dual_io_descr: assert property (rd_done && sel_dw3 |-> prdata[31:16] == 16'hBB80)
        else $error("dual-I/O descriptor wrong");

    a_word_ref: assert property (rd_done && sel_table |-> prdata == ref_word)
        else $error("table word differs from reference bytes");

    // ---------------------------------------------------------------
    // lookup and bus answer checks
    // ---------------------------------------------------------------
    a_lookup_any: assert property (cmd_write && wr_op == 8'h5A && wr_addr[7:4] == 4'h3
                                   |=> result_valid && result_data == ref_byte(cmd_addr[3:0]))
        else $error("lookup byte differs from reference");

    a_lookup_range: assert property (cmd_write && wr_addr[7:4] != 4'h3
                                     |=> result_refused && result_data == 8'hFF)
        else $error("lookup outside the table not refused");

    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");

    a_idle_data_zero: assert property (!pready |-> prdata == 32'h00000000)
        else $error("prdata not zero outside the answer cycle");

    a_read_ok: assert property (access_first && !pwrite && mapped |=> pready && !pslverr)
        else $error("read of a mapped register refused");

    a_unmapped_err: assert property (access_first && !mapped |=> pready && pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    a_cmd_write_ok: assert property (access_first && pwrite && sel_cmd |=> pready && !pslverr)
        else $error("command write refused");

    a_ro_unchanged: assert property (access_done && pwrite && !sel_cmd
                                     |=> $stable(result_data) && $stable(cmd_addr))
        else $error("refused write changed the lookup state");

    // shadow of the last accepted command, decoded here from the bus
    // so the readback is not checked against the register it reads
    logic [15:0] seen_cmd;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_cmd <= 16'h0000;
        end else if (access_done && pwrite && paddr == 8'h80) begin
            seen_cmd <= pwdata[15:0];
        end
    end

    a_cmd_readback: assert property (rd_done && paddr == 8'h80 |-> prdata == {16'h0000, seen_cmd})
        else $error("command readback differs from last write");

    // cycles that psel and penable have stood without an answer;
    // a pready stuck low would let this climb where the pulse check sleeps
    logic [1:0] wait_len;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_len <= 2'h0;
        end else if (access_first) begin
            wait_len <= (wait_len == 2'h3) ? 2'h3 : wait_len + 2'h1;
        end else begin
            wait_len <= 2'h0;
        end
    end

    a_wait_bounded: assert property (wait_len <= 2'h1)
        else $error("access phase stretched beyond one wait state");

    // ---------------------------------------------------------------
    // covers
    // ---------------------------------------------------------------
    c_read_dw0:   cover property (rd_done && paddr == 8'h30);
    c_lookup_ok:  cover property (cmd_write && lookup_ok);
    c_lookup_bad: cover property (cmd_write && !lookup_ok);
    c_back2back:  cover property (access_done ##[2:3] access_first);
    c_unmapped:   cover property (access_first && !mapped);

endmodule // sfdp_basic_param_table

// File: common/sfdp_pkg.sv
// ---------------------------------------------------------------
// sfdp_pkg: constants for the basic flash parameter table block
// ---------------------------------------------------------------
// holds the APB register map, the table contents and the field layouts
// assumes an 8-bit APB byte address and 32-bit data
package sfdp_pkg;

    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;

    // ---------------------------------------------------------------
    // register map (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0]  OFF_HDR_PTR     = 8'h0C;
    localparam logic [7:0]  OFF_TBL_DW0     = 8'h30;
    localparam logic [7:0]  OFF_TBL_DW1     = 8'h34;
    localparam logic [7:0]  OFF_TBL_DW2     = 8'h38;
    localparam logic [7:0]  OFF_TBL_DW3     = 8'h3C;
    localparam logic [7:0]  OFF_CMD         = 8'h80;
    localparam logic [7:0]  OFF_RESULT      = 8'h84;

    // table byte window
    localparam logic [7:0]  TBL_FIRST       = 8'h30;
    localparam logic [7:0]  TBL_LAST        = 8'h3F;

    // ---------------------------------------------------------------
    // byte 30H and 31H fields
    // ---------------------------------------------------------------
    localparam logic [1:0]  ERASE_4K_AVAIL  = 2'h1;
    localparam logic        GRAN_64_PLUS    = 1'b1;
    localparam logic        BP_VOLATILE     = 1'b0;
    localparam logic        WREN_SEL_06     = 1'b0;
    localparam logic [2:0]  BYTE30_FIXED    = 3'h7;
    localparam logic [7:0]  ERASE_4K_OP     = 8'h20;

    // ---------------------------------------------------------------
    // byte 32H and 33H fields
    // ---------------------------------------------------------------
    localparam logic        RD_112_OK       = 1'b1;
    localparam logic [1:0]  ADDR_3B_ONLY    = 2'h0;
    localparam logic        DTR_OK          = 1'b0;
    localparam logic        RD_122_OK       = 1'b1;
    localparam logic        RD_144_OK       = 1'b0;
    localparam logic        RD_114_OK       = 1'b0;
    localparam logic        BYTE32_B7       = 1'b1;
    localparam logic [7:0]  UNUSED_BYTE     = 8'hFF;

    // ---------------------------------------------------------------
    // read descriptors: {mode bits, wait states}, opcode
    // ---------------------------------------------------------------
    localparam logic [4:0]  QUAD_WAIT       = 5'h00;
    localparam logic [2:0]  QUAD_MODE       = 3'h0;
    localparam logic [7:0]  QUAD_OP         = 8'hFF;
    localparam logic [4:0]  RD112_WAIT      = 5'h08;
    localparam logic [2:0]  RD112_MODE      = 3'h0;
    localparam logic [7:0]  RD112_OP        = 8'h3B;
    localparam logic [4:0]  RD122_WAIT      = 5'h00;
    localparam logic [2:0]  RD122_MODE      = 3'h4;
    localparam logic [7:0]  RD122_OP        = 8'hBB;

    // header pointer dword: pointer low/mid/high, then unused byte
    localparam logic [23:0] TBL_POINTER     = 24'h000030;

    // discoverable-parameter read opcode
    localparam logic [7:0]  OP_SFDP_READ    = 8'h5A;

    // result register fields
    localparam int          RES_VALID_BIT   = 8;
    localparam int          RES_REFUSE_BIT  = 9;

endpackage

// File: dv/sfdp_host.sv
// sfdp_host: behavioural apb master standing in for the parameter-reading host
// assumes one pclk domain and a slave that answers by raising pready
`timescale 1ns/1ps
module sfdp_host
    import sfdp_pkg::*;
(
    input  wire logic              pclk,
    output logic                   psel,
    output logic                   penable,
    output logic                   pwrite,
    output logic [ADDR_W-1:0]      paddr,
    output logic [DATA_W-1:0]      pwdata,
    input  wire logic [DATA_W-1:0] prdata,
    input  wire logic              pready,
    input  wire logic              pslverr
);
    initial begin
        psel    <= 1'b0;
        penable <= 1'b0;
        pwrite  <= 1'b0;
        paddr   <= '0;
        pwdata  <= '0;
    end
    // ---------------------------------------------------------------
    // one transfer: setup, then access held until pready at an edge
    // ---------------------------------------------------------------
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // released lines flip so a stale value is never mistaken for a live one
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // sfdp_host

// File: dv/tb_sfdp_basic_param_table.sv
// tb_sfdp_basic_param_table: self-checking bench for the parameter table block
// assumes sfdp_pkg and the host model are compiled first
`timescale 1ns/1ps
module tb_sfdp_basic_param_table;
    import sfdp_pkg::*;
    localparam logic [31:0] DENS = 32'h1F3C5A96; // arbitrary density word
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [31:0]       exp_w [4];
    int                fails, compares;

    sfdp_basic_param_table #(.DENSITY_WORD(DENS)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    sfdp_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    always #5 pclk = ~pclk;
    // ---------------------------------------------------------------
    // compare and bus helpers
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
                       input logic ee, input string what);
        host.xfer(wr, a, d, rd, er);
        if (!wr) chk(what, e, rd);
        chk({what, " error"}, {31'h0, ee}, {31'h0, er});
    endtask
    task automatic stop_test;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_table;
        acc(1'b0, 8'h30, '0, exp_w[0], 1'b0, "word 30H");
        acc(1'b0, 8'h34, '0, exp_w[1], 1'b0, "word 34H");
        acc(1'b0, 8'h38, '0, exp_w[2], 1'b0, "word 38H");
        acc(1'b0, 8'h3C, '0, exp_w[3], 1'b0, "word 3CH");
        acc(1'b0, 8'h0C, '0, 32'hFF000030, 1'b0, "header pointer");
    endtask
    task automatic t_readonly;
        acc(1'b1, 8'h30, 32'h00000000, '0, 1'b1, "write table");
        acc(1'b1, 8'h3C, 32'hFFFFFFFF, '0, 1'b1, "write table");
        acc(1'b1, 8'h84, 32'h000001FF, '0, 1'b1, "write result");
        acc(1'b0, 8'h30, '0, exp_w[0], 1'b0, "table after write");
        acc(1'b0, 8'h3C, '0, exp_w[3], 1'b0, "table after write");
    endtask
    task automatic t_cmd;
        logic [3:0] j;
        for (int i = 0; i < 16; i++) begin
            j = 4'(i);
            acc(1'b1, 8'h80, {16'h0, 8'h30 + 8'(i), 8'h5A}, '0, 1'b0, "cmd write");
            acc(1'b0, 8'h84, '0, {22'h0, 2'h1, exp_w[j[3:2]][8 * j[1:0] +: 8]}, 1'b0, "byte fetch");
        end
        acc(1'b0, 8'h80, '0, 32'h00003F5A, 1'b0, "cmd readback");
        acc(1'b1, 8'h80, 32'h00003003, '0, 1'b0, "cmd wrong op");
        acc(1'b0, 8'h84, '0, 32'h000002FF, 1'b0, "refused op");
        acc(1'b1, 8'h80, 32'h00002F5A, '0, 1'b0, "cmd below");
        acc(1'b0, 8'h84, '0, 32'h000002FF, 1'b0, "refused low");
        acc(1'b1, 8'h80, 32'h0000405A, '0, 1'b0, "cmd above");
        acc(1'b0, 8'h84, '0, 32'h000002FF, 1'b0, "refused high");
    endtask
    task automatic t_unmapped_reset;
        acc(1'b0, 8'h90, '0, 32'h0, 1'b1, "unmapped read");
        acc(1'b1, 8'h80, 32'h0000395A, '0, 1'b0, "cmd before reset");
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, 8'h84, '0, 32'h0, 1'b0, "result after reset");
        acc(1'b0, 8'h30, '0, exp_w[0], 1'b0, "table after reset");
    endtask

    initial begin
        pclk     = 1'b0;
        presetn  <= 1'b0;
        fails    = 0;
        compares = 0;
        // bytes 30H..3FH, lowest byte in bits 7:0
        exp_w    = '{32'hFF9120E5, DENS, 32'hFF00FF00, 32'hBB803B08};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_table;
        t_readonly;
        t_cmd;
        t_unmapped_reset;
        stop_test;
    end
    // whole run needs well under 1000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        stop_test;
    end
endmodule // tb_sfdp_basic_param_table
